// file: src/oreg_pkg.sv
`default_nettype none

package oreg_pkg;

    typedef enum logic [1:0] {
        OREG_SDR,
        OREG_GDDR,
        OREG_MDDR
    } oreg_mode_t;

    localparam int OREG_DATA_W = 1;
    localparam int OREG_FIFO_DEPTH = 4;
    localparam int OREG_CLOCK_PERIOD_NS = 40;
    localparam logic OREG_RIGHT_EDGE_DEF = 1'h1;
    localparam logic [1:0] OREG_RST_SYNC_INIT = 2'h0;

    // stages off the right edge have no strobe path, so memory mode folds to generic
    function automatic oreg_mode_t oregResolveMode(input oreg_mode_t req, input logic rightEdge);
        oreg_mode_t res;
        res = req;
        if (req == OREG_MDDR && !rightEdge) begin
            res = OREG_GDDR;
        end else if (req != OREG_SDR && req != OREG_GDDR && req != OREG_MDDR) begin
            res = OREG_SDR;
        end
        return res;
    endfunction

endpackage

`default_nettype wire

// file: src/oreg_stream_if.sv
`default_nettype none

interface oreg_stream_if #(
    parameter int WIDTH = 2
) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (
        output valid,
        output data,
        input ready
    );

    modport sink (
        input valid,
        input data,
        output ready
    );
endinterface

`default_nettype wire

// file: src/oreg_fifo.sv
`default_nettype none

module oreg_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = oreg_pkg::OREG_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rstN,
    oreg_stream_if.sink fillSide,
    oreg_stream_if.source drainSide
);
    import oreg_pkg::*;

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [PTR_W:0] count;
        logic inReady;
    } oreg_fifo_state_t;

    oreg_fifo_state_t q;
    oreg_fifo_state_t d;
    logic push;
    logic pop;

    // depth need not be a power of two, so pointers wrap explicitly
    function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
        if (p == PTR_W'(DEPTH - 1)) begin
            return '0;
        end
        return p + PTR_W'(1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        push = fillSide.valid && q.inReady;
        pop = drainSide.ready && (q.count != '0);
        d = q;
        if (push) begin
            d.mem[q.wrPtr] = fillSide.data;
            d.wrPtr = nextPtr(q.wrPtr);
        end
        if (pop) begin
            d.rdPtr = nextPtr(q.rdPtr);
        end
        if (push && !pop) begin
            d.count = q.count + (PTR_W + 1)'(1);
        end else if (pop && !push) begin
            d.count = q.count - (PTR_W + 1)'(1);
        end
        // registered ready: taken from the next count, so full shows with no lag, never overruns
        d.inReady = (d.count != (PTR_W + 1)'(DEPTH));
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fillSide.ready = q.inReady;
    assign drainSide.valid = (q.count != '0);
    assign drainSide.data = q.mem[q.rdPtr];

    ////////////////////////////////////////////////////////////////////////////////
    no_overrun_a: assert property (@(posedge clock) disable iff (!rstN)
        q.count <= (PTR_W + 1)'(DEPTH)) else $error("fifo count above depth");
    full_stall_a: assert property (@(posedge clock) disable iff (!rstN)
        (q.count == (PTR_W + 1)'(DEPTH)) |-> !q.inReady) else $error("ready while full");

endmodule

`default_nettype wire

// file: src/oreg_output_block.sv
`default_nettype none

module oreg_output_block #(
    parameter int WIDTH = oreg_pkg::OREG_DATA_W,
    parameter int DEPTH = oreg_pkg::OREG_FIFO_DEPTH,
    parameter logic RIGHT_EDGE = oreg_pkg::OREG_RIGHT_EDGE_DEF
) (
    input wire logic clock,
    input wire logic nrst,
    input wire oreg_pkg::oreg_mode_t modeSel,
    input wire logic latchSel,
    input wire logic quarterShiftedWriteStrobe,
    input wire logic [WIDTH-1:0] firstPhaseData,
    input wire logic [WIDTH-1:0] secondPhaseData,
    input wire logic dataValid,
    output logic dataReady,
    input wire logic holdOutput,
    output logic pairTaken,
    output logic [WIDTH-1:0] pinOut
);
    import oreg_pkg::*;

    typedef struct packed {
        oreg_mode_t mode;
        logic latchMode;
        logic [WIDTH-1:0] sdrReg;
        logic [WIDTH-1:0] riseCapture;
        logic [WIDTH-1:0] secondCapture;
        logic pairTaken;
    } oreg_core_t;

    logic [1:0] rstSync_q;
    logic rstN;
    oreg_core_t q;
    oreg_core_t d;
    logic [WIDTH-1:0] fallRetime_q;
    logic [WIDTH-1:0] latchStore;
    logic pop;
    logic [WIDTH-1:0] headFirst;
    logic [WIDTH-1:0] headSecond;
    logic muxSel;

    oreg_stream_if #(.WIDTH(2 * WIDTH)) fillIf ();
    oreg_stream_if #(.WIDTH(2 * WIDTH)) drainIf ();

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstSync_q <= OREG_RST_SYNC_INIT;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'h1};
        end
    end
    assign rstN = rstSync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // core data is queued, never sent to the pin directly
    assign fillIf.valid = dataValid;
    assign fillIf.data = {firstPhaseData, secondPhaseData};
    assign dataReady = fillIf.ready;

    oreg_fifo #(
        .WIDTH(2 * WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rstN(rstN),
        .fillSide(fillIf.sink),
        .drainSide(drainIf.source)
    );

    // the stage drains one pair per clock unless the core holds it back
    assign drainIf.ready = !holdOutput;
    assign pop = drainIf.valid && drainIf.ready;
    assign headFirst = drainIf.data[2*WIDTH-1:WIDTH];
    assign headSecond = drainIf.data[WIDTH-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.mode = oregResolveMode(modeSel, RIGHT_EDGE);
        d.latchMode = latchSel;
        d.pairTaken = pop;
        if (pop) begin
            if (q.mode == OREG_SDR) begin
                d.sdrReg = headFirst;
            end else begin
                // memory mode captures exactly like generic
                d.riseCapture = headFirst;
                d.secondCapture = headSecond;
            end
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // half-cycle retime of the second bit
    always_ff @(negedge clock or negedge rstN) begin
        if (!rstN) begin
            fallRetime_q <= '0;
        end else if (q.mode != OREG_SDR) begin
            fallRetime_q <= q.secondCapture;
        end
    end

    // latch option: open while clock is high and a pair is taken in single rate mode
    always_latch begin
        if (!rstN) begin
            latchStore <= '0;
        end else if (clock && pop && q.mode == OREG_SDR) begin
            latchStore <= headFirst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // double rate cannot come straight from one flop: the pin is the mux of two
    always_comb begin
        case (q.mode)
            OREG_GDDR: muxSel = clock;
            OREG_MDDR: muxSel = quarterShiftedWriteStrobe;
            default: muxSel = 1'h0;
        endcase
    end

    always_comb begin
        case (q.mode)
            OREG_SDR: pinOut = q.latchMode ? latchStore : q.sdrReg;
            OREG_GDDR,
            OREG_MDDR: pinOut = muxSel ? q.riseCapture : fallRetime_q;
            default: pinOut = q.sdrReg;
        endcase
    end

    assign pairTaken = q.pairTaken;

    ////////////////////////////////////////////////////////////////////////////////
    // checks; sampled at the rising edge, where the clock itself reads low
    sequence capStep;
        pop && (q.mode != OREG_SDR) && (d.mode == q.mode);
    endsequence

    sequence retimeStep(logic [WIDTH-1:0] second);
        (fallRetime_q == second) && (q.secondCapture == second);
    endsequence

    property captureThenRetime;
        logic [WIDTH-1:0] s;
        @(posedge clock) disable iff (!rstN)
        (capStep, s = headSecond) |=> retimeStep(s);
    endproperty

    fifo_path_a: assert property (@(posedge clock) disable iff (!rstN)
        pop |=> pairTaken) else $error("drained pair not flagged");

    hold_stall_a: assert property (@(posedge clock) disable iff (!rstN)
        holdOutput |=> !pairTaken) else $error("pair taken during hold");

    sdr_capture_a: assert property (@(posedge clock) disable iff (!rstN)
        (pop && q.mode == OREG_SDR) |=> q.sdrReg == $past(headFirst))
        else $error("single rate flop missed data");

    sdr_flop_pin_a: assert property (@(posedge clock) disable iff (!rstN)
        (q.mode == OREG_SDR && !q.latchMode) |-> pinOut == q.sdrReg)
        else $error("flop mode pin mismatch");

    sdr_latch_pin_a: assert property (@(posedge clock) disable iff (!rstN)
        (q.mode == OREG_SDR && q.latchMode) |-> pinOut == latchStore)
        else $error("latch mode pin mismatch");

    ddr_capture_a: assert property (@(posedge clock) disable iff (!rstN)
        (pop && q.mode == OREG_GDDR) |=>
        (q.riseCapture == $past(headFirst)) && (q.secondCapture == $past(headSecond)))
        else $error("generic capture wrong");

    fall_retime_a: assert property (@(posedge clock) disable iff (!rstN)
        (q.mode != OREG_SDR) && $stable(q.mode) && $past(q.mode != OREG_SDR) |->
        fallRetime_q == q.secondCapture) else $error("falling retime stale");

    retime_seq_a: assert property (captureThenRetime)
        else $error("capture not followed by retime");

    gddr_low_pin_a: assert property (@(posedge clock) disable iff (!rstN)
        (q.mode == OREG_GDDR) |-> pinOut == fallRetime_q)
        else $error("generic mux low phase wrong");

    mode_fold_a: assert property (@(posedge clock) disable iff (!rstN)
        (modeSel == OREG_MDDR) |=> q.mode == (RIGHT_EDGE ? OREG_MDDR : OREG_GDDR))
        else $error("memory mode on wrong edge");

    mddr_capture_a: assert property (@(posedge clock) disable iff (!rstN)
        (pop && q.mode == OREG_MDDR) |=>
        (q.riseCapture == $past(headFirst)) && (q.secondCapture == $past(headSecond)))
        else $error("memory capture wrong");

    mddr_high_pin_a: assert property (@(posedge clock) disable iff (!rstN)
        (q.mode == OREG_MDDR && quarterShiftedWriteStrobe) |-> pinOut == q.riseCapture)
        else $error("strobe high pin wrong");

    mddr_low_pin_a: assert property (@(posedge clock) disable iff (!rstN)
        (q.mode == OREG_MDDR && !quarterShiftedWriteStrobe) |-> pinOut == fallRetime_q)
        else $error("strobe low pin wrong");

endmodule

`default_nettype wire

// file: dv/oreg_core_model.sv
`default_nettype none

module oreg_core_model (
    input wire logic clock,
    input wire logic rstN,
    input wire logic [7:0] sendLimit,
    input wire logic dataReady,
    output logic dataValid,
    output logic firstPhaseData,
    output logic secondPhaseData,
    output logic [7:0] sentCount
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] nextCount;

    assign nextCount = sentCount + {7'h0, dataValid & dataReady};

    // pair k carries its index bits: first = k[0], second = k[1]
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            dataValid <= 1'h0;
            firstPhaseData <= 1'h0;
            secondPhaseData <= 1'h0;
            sentCount <= 8'h0;
        end else begin
            sentCount <= nextCount;
            dataValid <= (nextCount != sendLimit);
            if (nextCount != sendLimit) begin
                // held unchanged until the edge that takes it
                firstPhaseData <= nextCount[0];
                secondPhaseData <= nextCount[1];
            end else begin
                // idle lines toggle so no stale value passes for data
                firstPhaseData <= ~firstPhaseData;
                secondPhaseData <= ~secondPhaseData;
            end
        end
    end
endmodule

`default_nettype wire

// file: dv/oreg_output_block_bench.sv
`default_nettype none

module oreg_output_block_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import oreg_pkg::*;

    logic clock, nrst, latchSel, strobe, dataValid, dataReady, holdOutput, pairTaken;
    logic firstBit, secondBit, pinOut;
    oreg_mode_t modeSel;
    logic [7:0] sendLimit, sentCount;
    int badCount, checksDone, pairIdx;

    oreg_output_block oreg_output_block_inst (
        .clock(clock), .nrst(nrst), .modeSel(modeSel), .latchSel(latchSel),
        .quarterShiftedWriteStrobe(strobe), .firstPhaseData(firstBit),
        .secondPhaseData(secondBit), .dataValid(dataValid), .dataReady(dataReady),
        .holdOutput(holdOutput), .pairTaken(pairTaken), .pinOut(pinOut)
    );

    oreg_core_model oreg_core_model_inst (
        .clock(clock), .rstN(nrst), .sendLimit(sendLimit), .dataReady(dataReady),
        .dataValid(dataValid), .firstPhaseData(firstBit), .secondPhaseData(secondBit),
        .sentCount(sentCount)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finishTest();
        if (badCount == 0 && checksDone > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // samples each phase mid-way, clear of both edges
    task automatic drain_check(input int n);
        int waits;
        int shown;
        int prevIdx;
        logic riseExp, lowExp;
        for (int k = 0; k < n; k++) begin
            waits = 0;
            // latch opens on the draining cycle, so it already passes the next queued pair
            shown = (latchSel && modeSel == OREG_SDR && k < n - 1) ? pairIdx + 1 : pairIdx;
            prevIdx = pairIdx - 1;
            do begin
                @(posedge clock);
                #10;
                waits++;
            end while (pairTaken !== 1'h1 && waits < 50);
            check("pair taken", {7'h0, pairTaken}, 8'h1);
            if (k > 0) check("drain gap", waits[7:0], 8'h1);
            // a low strobe shows the retime register, still the previous pair here
            riseExp = (modeSel == OREG_MDDR && !strobe) ? prevIdx[1] : shown[0];
            check("rise phase", {7'h0, pinOut}, {7'h0, riseExp});
            lowExp = (modeSel == OREG_SDR || (modeSel == OREG_MDDR && strobe)) ?
                shown[0] : pairIdx[1];
            #20;
            check("fall phase", {7'h0, pinOut}, {7'h0, lowExp});
            pairIdx++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic reset_check();
        repeat (12) @(posedge clock);
        check("reset pin", {7'h0, pinOut}, 8'h0);
        check("reset ready", {7'h0, dataReady}, 8'h0);
        check("reset taken", {7'h0, pairTaken}, 8'h0);
        nrst <= 1'h1;
        repeat (4) @(posedge clock);
        #10;
        check("ready after reset", {7'h0, dataReady}, 8'h1);
    endtask

    task automatic run_mode(input oreg_mode_t mode, input logic latch, input logic strb);
        @(posedge clock);
        modeSel <= mode;
        latchSel <= latch;
        strobe <= strb;
        repeat (2) @(posedge clock);
        sendLimit <= sendLimit + 8'h4;
        drain_check(4);
    endtask

    // stall the drain: four pairs stored, fifth refused, then all leave in order
    task automatic flood_check();
        @(posedge clock);
        modeSel <= OREG_GDDR;
        holdOutput <= 1'h1;
        sendLimit <= sendLimit + 8'h6;
        repeat (12) @(posedge clock);
        #10;
        check("full ready", {7'h0, dataReady}, 8'h0);
        check("stored pairs", sentCount, 8'(pairIdx + 4));
        @(posedge clock);
        holdOutput <= 1'h0;
        drain_check(6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #(OREG_CLOCK_PERIOD_NS / 2) clock = ~clock;
    end

    initial begin
        #200000;
        badCount++;
        finishTest();
    end

    initial begin
        nrst = 1'h0;
        modeSel = OREG_SDR;
        latchSel = 1'h0;
        strobe = 1'h1;
        holdOutput = 1'h0;
        sendLimit = 8'h0;
        badCount = 0;
        checksDone = 0;
        pairIdx = 0;
        reset_check();
        run_mode(OREG_SDR, 1'h0, 1'h1);
        run_mode(OREG_SDR, 1'h1, 1'h1);
        run_mode(OREG_GDDR, 1'h0, 1'h1);
        run_mode(OREG_MDDR, 1'h0, 1'h1);
        run_mode(OREG_MDDR, 1'h0, 1'h0);
        flood_check();
        finishTest();
    end
endmodule

`default_nettype wire
